// *** cmrr_host.sv ***
// Host model reading the result registers.
// Assumes read is called just after a falling mclk edge.
`timescale 1ns/1ps
`default_nettype none
module cmrr_host
(
  input  wire logic       mclk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            rd_en = 1'b0,
  output logic [7:0]      rd_addr = 8'h00
);
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    d = rd_data;
    v = rd_valid;
    rd_en = 1'b0;
    rd_addr = ~a;
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// *** cmrr_pkg.sv ***
// Package for the current monitor readback register bank.
// Assumes an 8-bit register read port driven by the serial management logic.
package cmrr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] CMRR_OFS_IN_HIGH   = 8'h3e;
  localparam logic [7:0] CMRR_OFS_IN_LOW    = 8'h3f;
  localparam logic [7:0] CMRR_OFS_BAT_HIGH  = 8'h40;
  localparam logic [7:0] CMRR_OFS_BAT_LOW   = 8'h41;

  // ==========================================================================
  // Field layout and reset values
  localparam int         CMRR_SIGN_BIT      = 12;
  localparam int         CMRR_HIGH_MSB      = 4;
  localparam logic [7:0] CMRR_REG_RESET     = 8'h00;
  localparam logic [2:0] CMRR_RESERVED_VAL  = 3'h0;

  // ==========================================================================
  // Full-scale codes and scaling
  localparam logic [11:0] CMRR_IN_FULL_SCALE  = 12'hc5d;
  localparam logic [11:0] CMRR_BAT_FULL_SCALE = 12'hd80;
  localparam real         CMRR_IN_LSB_MA      = 1.5873;
  localparam real         CMRR_BAT_LSB_MA     = 1.2210;
  localparam int          CMRR_IN_LIMIT_MA    = 5024;
  localparam int          CMRR_BAT_LIMIT_MA   = 4220;

  // ==========================================================================
  // Converter sample carrier
  typedef struct packed {
    logic        valid;
    logic        negative;
    logic [12:0] magnitude;
  } cmrr_sample_t;

  // Stored 13-bit result: sign plus 12-bit magnitude
  typedef struct packed {
    logic        sign;
    logic [11:0] mag;
  } cmrr_result_t;

endpackage

// *** cmrr_regs.sv ***
// Read-only result registers for the input-port and battery current channels.
// Assumes converter samples arrive on mclk with a one-cycle valid, and the
// management port presents a one-cycle read strobe with an 8-bit address.
`timescale 1ns/1ps
`default_nettype none

module cmrr_regs
  import cmrr_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire cmrr_sample_t input_port_current,
  input  wire cmrr_sample_t battery_current,
  input  wire logic         rd_en,
  input  wire logic [7:0]   rd_addr,
  output logic [7:0]        rd_data,
  output logic              rd_valid
);

  // ==========================================================================
  // Channel map: index 0 is the input port, index 1 the battery
  localparam int CMRR_CHANNELS = 2;

  // ==========================================================================
  // Saturating conversion of a sample into a stored result
  // Magnitude bit 12 only takes part in the range compare; it is never stored.
  function automatic cmrr_result_t cmrr_clamp(
    input cmrr_sample_t s,
    input logic [11:0]  full
  );
    cmrr_result_t r;
    logic         over_range;
    over_range = (s.magnitude > {1'b0, full});
    r.sign     = s.negative;
    if (over_range)
    begin
      r.mag = full;
    end
    else
    begin
      r.mag = s.magnitude[11:0];
    end
    return r;
  endfunction

  // ==========================================================================
  // Per-channel wiring
  cmrr_sample_t chan_sample   [CMRR_CHANNELS];
  logic [11:0]  chan_full     [CMRR_CHANNELS];
  logic [7:0]   chan_high_ofs [CMRR_CHANNELS];
  logic [7:0]   chan_low_ofs  [CMRR_CHANNELS];
  logic [7:0]   high_byte     [CMRR_CHANNELS];
  logic [7:0]   low_byte      [CMRR_CHANNELS];
  logic [7:0]   next_rd_data;
  logic         next_rd_valid;

  assign chan_sample[0]   = input_port_current;
  assign chan_sample[1]   = battery_current;
  assign chan_full[0]     = CMRR_IN_FULL_SCALE;
  assign chan_full[1]     = CMRR_BAT_FULL_SCALE;
  assign chan_high_ofs[0] = CMRR_OFS_IN_HIGH;
  assign chan_high_ofs[1] = CMRR_OFS_BAT_HIGH;
  assign chan_low_ofs[0]  = CMRR_OFS_IN_LOW;
  assign chan_low_ofs[1]  = CMRR_OFS_BAT_LOW;

  // ==========================================================================
  // Result store and coherent low-byte snapshot, one copy per channel
  for (genvar ch = 0; ch < CMRR_CHANNELS; ch++)
  begin : g_chan
    cmrr_result_t res;
    cmrr_result_t next_res;
    cmrr_result_t clamped;
    logic [7:0]   low_hold;
    logic [7:0]   next_low_hold;
    logic         frozen;
    logic         next_frozen;
    logic [12:0]  word;
    logic         hit_high;
    logic         hit_low;

    assign word     = {res.sign, res.mag};
    assign clamped  = cmrr_clamp(chan_sample[ch], chan_full[ch]);
    assign hit_high = rd_en && (rd_addr == chan_high_ofs[ch]);
    assign hit_low  = rd_en && (rd_addr == chan_low_ofs[ch]);

    // Reserved bits 7:5 always read as zero
    assign high_byte[ch] = {CMRR_RESERVED_VAL, word[CMRR_SIGN_BIT:8]};
    // A pending snapshot wins over the live byte so both halves match
    assign low_byte[ch]  = frozen ? low_hold : word[7:0];

    always_comb
    begin
      next_res      = res;
      next_low_hold = low_hold;
      next_frozen   = frozen;
      if (chan_sample[ch].valid)
      begin
        next_res = clamped;
      end
      // Snapshot takes the stored result, not a sample landing in this cycle.
      // A second high read simply takes a fresh snapshot.
      if (hit_high)
      begin
        next_low_hold = word[7:0];
        next_frozen   = 1'b1;
      end
      else if (hit_low)
      begin
        next_frozen = 1'b0;
      end
    end

    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        res      <= '0;
        low_hold <= CMRR_REG_RESET;
        frozen   <= 1'b0;
      end
      else
      begin
        res      <= next_res;
        low_hold <= next_low_hold;
        frozen   <= next_frozen;
      end
    end
  end

  // ==========================================================================
  // Read port: one registered answer per strobe
  // Unmapped offsets still answer, with zero data, so the host never stalls.
  always_comb
  begin
    next_rd_valid = rd_en;
    next_rd_data  = CMRR_REG_RESET;
    if (rd_en)
    begin
      unique case (rd_addr)
        CMRR_OFS_IN_HIGH:
        begin
          next_rd_data = high_byte[0];
        end
        CMRR_OFS_IN_LOW:
        begin
          next_rd_data = low_byte[0];
        end
        CMRR_OFS_BAT_HIGH:
        begin
          next_rd_data = high_byte[1];
        end
        CMRR_OFS_BAT_LOW:
        begin
          next_rd_data = low_byte[1];
        end
        default:
        begin
          next_rd_data = CMRR_REG_RESET;
        end
      endcase
    end
  end

  // Data returns to zero when idle so a stale value is never mistaken for news
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rd_data  <= CMRR_REG_RESET;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

endmodule

`default_nettype wire

// *** cmrr_regs_asserts.sv ***
// Port checker for the current result registers.
// Assumes the bind below attaches it to each cmrr_regs.
`timescale 1ns/1ps
`default_nettype none
module cmrr_regs_asserts
  import cmrr_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst_n,
  input wire cmrr_sample_t input_port_current,
  input wire cmrr_sample_t battery_current,
  input wire logic         rd_en,
  input wire logic [7:0]   rd_addr,
  input wire logic [7:0]   rd_data,
  input wire logic         rd_valid
);
  cmrr_sample_t ip;
  cmrr_sample_t bp;
  logic         rin;
  logic         rbt;
  assign ip = input_port_current;
  assign bp = battery_current;
  assign rin = rd_en && rd_addr == 8'h3e && !ip.valid;
  assign rbt = rd_en && rd_addr == 8'h40 && !bp.valid;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (rd_en |=> rd_valid) else $error("no answer");
  a_idle_quiet: assert property (!rd_en |=> !rd_valid && rd_data == 8'h00) else $error("idle");
  a_unmapped_zero: assert property (rd_en && rd_addr > 8'h41 |=> rd_data == 8'h00) else $error("unmapped");
  a_high_reserved: assert property (rin |=> rd_data[7:5] == 3'h0) else $error("reserved");
  a_in_clamp: assert property (ip.valid && ip.magnitude > 13'h0c5d ##1 rin |=> rd_data[3:0] == 4'hc)
    else $error("in clamp");
  a_bat_clamp: assert property (bp.valid && bp.magnitude > 13'h0d80 ##1 rbt |=> rd_data[3:0] == 4'hd)
    else $error("bat clamp");
  a_in_sign: assert property (ip.valid ##1 rin |=> rd_data[4] == $past(ip.negative, 2)) else $error("in sign");
  a_bat_sign: assert property (bp.valid ##1 rbt |=> rd_data[4] == $past(bp.negative, 2))
    else $error("bat sign");
endmodule
bind cmrr_regs cmrr_regs_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .input_port_current(input_port_current),
  .battery_current(battery_current), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
`default_nettype wire

// *** cmrr_regs_tb.sv ***
// Bench for the current result registers.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module cmrr_regs_tb;
  import cmrr_pkg::*;
  logic         mclk = 1'b0;
  logic         rst_n = 1'b0;
  cmrr_sample_t in_s = '0;
  cmrr_sample_t bat_s = '0;
  logic         rd_en;
  logic [7:0]   rd_addr;
  logic [7:0]   rd_data;
  logic         rd_valid;
  int           errors;
  int           check_count;
  cmrr_regs dut (.mclk(mclk), .rst_n(rst_n), .input_port_current(in_s), .battery_current(bat_s),
                 .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
  cmrr_host host (.mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid), .rd_en(rd_en), .rd_addr(rd_addr));
  initial forever #50 mclk = ~mclk;
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] a, e, s);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] reg %h expected %h seen %h", a, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] d;
    logic       v;
    host.read(a, d, v);
    chk(a, e, d);
    chk(a, 8'h01, {7'h00, v});
  endtask
  task automatic samp(input logic b, n, input logic [12:0] m);
    if (b)
      bat_s = {1'b1, n, m};
    else
      in_s = {1'b1, n, m};
    @(negedge mclk);
    in_s.valid = 1'b0;
    bat_s.valid = 1'b0;
  endtask
  task automatic t_input();
    samp(1'b0, 1'b0, 13'h1000);
    rd(8'h3e, 8'h0c);
    rd(8'h3f, 8'h5d);
    samp(1'b0, 1'b1, 13'h0123);
    rd(8'h3e, 8'h11);
    rd(8'h3f, 8'h23);
    samp(1'b0, 1'b0, 13'h0c5e);
    rd(8'h3f, 8'h5d);
  endtask
  task automatic t_battery();
    samp(1'b1, 1'b1, 13'h1fff);
    rd(8'h40, 8'h1d);
    rd(8'h41, 8'h80);
    samp(1'b1, 1'b0, 13'h0d7f);
    rd(8'h40, 8'h0d);
    samp(1'b1, 1'b0, 13'h0001);
    rd(8'h41, 8'h7f);
    rd(8'h41, 8'h01);
  endtask
  initial
  begin
    repeat (400) @(posedge mclk);
    errors++;
    print_verdict();
  end
  initial
  begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    for (int i = 0; i < 5; i++) rd(8'h3e + i[7:0], 8'h00);
    t_input();
    t_battery();
    print_verdict();
  end
endmodule
`default_nettype wire
